// *** common/sysctl_pkg.sv ***
// package: register map, field layout, reset values and sram ranges for the control bank
// ****************************************************************
// Behaviour
// (RULE_01) eight-bit read/write current multiplier register
// (RULE_02) current code counts unit currents, larger bigger
// (RULE_03) same code sets proximity detect charging current
// (RULE_04) repeated-boot flag bit 7 is read only
// (RULE_05) flag reads 0 after single boot
// (RULE_06) flag reads 1 after repeated boot
// (RULE_07) bits 4:3 pick oscillator range 12/6/24
// (RULE_08) software loads matching trim on range change
// (RULE_09) skip clear: sram cleared after any reset
// (RULE_10) skip set: page 0 03h-D7h kept on watchdog
// (RULE_11) software writes zero to reserved bits
// ****************************************************************
package sysctl_pkg;

    // register byte offsets (printed offsets are not word multiples: index times four)
    localparam logic [7:0]  IDX_CURRENT      = 8'hFD;
    localparam logic [7:0]  IDX_SYSCTL       = 8'hFE;
    localparam logic [11:0] ADDR_CURRENT     = 12'h3F4;
    localparam logic [11:0] ADDR_SYSCTL      = 12'h3F8;
    localparam int          ADDR_W           = 12;

    // field positions in the control register
    localparam int          BIT_REBOOT       = 7;
    localparam int          BIT_OSC_HI       = 4;
    localparam int          BIT_OSC_LO       = 3;
    localparam int          BIT_SKIP         = 0;

    // reset values
    localparam logic [7:0]  RST_CURRENT      = 8'h00;
    localparam logic [1:0]  RST_OSC          = 2'h0;
    localparam logic        RST_SKIP         = 1'b0;

    // sram clear window and kept range
    localparam logic [7:0]  SRAM_KEEP_LO     = 8'h03;
    localparam logic [7:0]  SRAM_KEEP_HI     = 8'hD7;
    localparam logic [7:0]  SRAM_LAST        = 8'hFF;

    // axi responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // oscillator range codes
    typedef enum logic [1:0] {
        OSC_12MHZ = 2'h0,
        OSC_6MHZ  = 2'h1,
        OSC_24MHZ = 2'h2,
        OSC_RSVD  = 2'h3
    } osc_range_t;

endpackage : sysctl_pkg

// *** common/sram_clear_if.sv ***
// interface: request and progress of the sram clear sequencer
`timescale 1ns/1ps
`default_nettype none
interface sram_clear_if;
    logic       start;      // one-cycle start pulse
    logic       keep_range; // skip 03h..D7h
    logic       busy;       // sequence running
    logic       wr_en;      // sram write strobe
    logic [7:0] wr_addr;    // sram page 0 address
    modport ctl (output start, output keep_range, input busy, input wr_en, input wr_addr);
    modport seq (input start, input keep_range, output busy, output wr_en, output wr_addr);
endinterface : sram_clear_if
`default_nettype wire

// *** src/sram_clear_seq.sv ***
// module: walks sram page 0 writing zero, optionally keeping a range
`timescale 1ns/1ps
`default_nettype none
module sram_clear_seq
    import sysctl_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // control
    sram_clear_if.seq clr
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic       busy;
        logic       keep;
        logic       wr_en;
        logic [7:0] addr;
    } seq_state_t;

    seq_state_t st;      // registered state
    seq_state_t next_st; // next state

    // kept address test
    function automatic logic in_keep(input logic [7:0] a);
        in_keep = (a >= SRAM_KEEP_LO) && (a <= SRAM_KEEP_HI);
    endfunction : in_keep

    // next state
    always_comb begin
        next_st = st;
        next_st.wr_en = 1'b0;
        if (!st.busy && clr.start) begin
            next_st.busy = 1'b1;
            next_st.keep = clr.keep_range;
            next_st.addr = 8'h00;
        end else if (st.busy) begin
            // write zero unless kept across watchdog [RULE_09] [RULE_10]
            next_st.wr_en = !(st.keep && in_keep(st.addr));
            if (st.addr == SRAM_LAST) begin
                next_st.busy = 1'b0;
            end
            next_st.addr = st.addr + 8'h01;
        end
    end

    // register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign clr.busy    = st.busy;
    assign clr.wr_en   = st.wr_en;
    assign clr.wr_addr = st.addr - 8'h01;

    a_kept_untouched: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.wr_en && st.keep) |-> !in_keep(clr.wr_addr))  // [RULE_10]
        else $error("kept sram address was cleared");
endmodule : sram_clear_seq
`default_nettype wire

// *** src/axil_reg_port.sv ***
// module: axi4-lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port
    import sysctl_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    // read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    // register side
    output var  logic              wr_stb,
    output var  logic [ADDR_W-1:0] wr_addr,
    output var  logic [7:0]        wr_data,
    output var  logic              rd_stb,
    output var  logic [ADDR_W-1:0] rd_addr,
    input  wire logic [7:0]        rd_data,
    input  wire logic              rd_hit,
    input  wire logic              wr_hit
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] aw;
        logic [7:0]        wd;
        logic              wl;
        logic              bv;
        logic [1:0]        br;
        logic              rv;
        logic [31:0]       rd;
        logic [1:0]        rr;
        logic              ws;
        logic              rs;
        logic [ADDR_W-1:0] ra;
    } port_state_t;

    port_state_t st;      // registered state
    port_state_t next_st; // next state

    // channel handshakes and response generation
    always_comb begin
        next_st = st;
        next_st.ws = 1'b0;
        next_st.rs = 1'b0;
        if (awvalid && !st.aw_got && !st.bv) begin
            next_st.aw_got = 1'b1;
            next_st.aw     = awaddr;
        end
        if (wvalid && !st.w_got && !st.bv) begin
            next_st.w_got = 1'b1;
            next_st.wd    = wdata[7:0];
            next_st.wl    = wstrb[0];
        end
        // both halves present: strobe register and answer
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.ws     = st.wl && wr_hit;
            next_st.bv     = 1'b1;
            next_st.br     = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.bv && bready) begin
            next_st.bv = 1'b0;
        end
        // read: capture address, data one cycle later
        if (arvalid && !st.rv && !st.rs) begin
            next_st.rs = 1'b1;
            next_st.ra = araddr;
        end
        if (st.rs) begin
            next_st.rv = 1'b1;
            next_st.rd = {24'h000000, rd_data};
            next_st.rr = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rv && rready) begin
            next_st.rv = 1'b0;
        end
    end

    // register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign awready = !st.aw_got && !st.bv;
    assign wready  = !st.w_got && !st.bv;
    assign bvalid  = st.bv;
    assign bresp   = st.br;
    assign arready = !st.rv && !st.rs;
    assign rvalid  = st.rv;
    assign rdata   = st.rd;
    assign rresp   = st.rr;
    assign wr_stb  = st.ws;
    assign wr_addr = st.aw;
    assign wr_data = st.wd;
    assign rd_stb  = st.rs;
    assign rd_addr = st.ra;
endmodule : axil_reg_port
`default_nettype wire

// *** src/system_control_regs.sv ***
// module: current setting and system status/control register bank
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module system_control_regs
    import sysctl_pkg::*;
(
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         ce,
    // axi4-lite write
    input  wire logic [sysctl_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                         s_awvalid,
    output var  logic                         s_awready,
    input  wire logic [31:0]                  s_wdata,
    input  wire logic [3:0]                   s_wstrb,
    input  wire logic                         s_wvalid,
    output var  logic                         s_wready,
    output var  logic [1:0]                   s_bresp,
    output var  logic                         s_bvalid,
    input  wire logic                         s_bready,
    // axi4-lite read
    input  wire logic [sysctl_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                         s_arvalid,
    output var  logic                         s_arready,
    output var  logic [31:0]                  s_rdata,
    output var  logic [1:0]                   s_rresp,
    output var  logic                         s_rvalid,
    input  wire logic                         s_rready,
    // reset cause inputs from the reset generator (pins or other logic, asynchronous, synchronised here)
    input  wire logic                         boot_done,
    input  wire logic                         por_event,
    input  wire logic                         external_reset_input,
    input  wire logic                         watchdog_reset_event,
    // analog current source and oscillator controls
    output var  logic [7:0]                   current_unit_count,
    output var  logic [7:0]                   proximity_unit_count,
    output var  logic [1:0]                   osc_range_select,
    output var  logic                         osc_range_valid,
    // sram clear port
    output var  logic                         sram_wr_en,
    output var  logic [7:0]                   sram_wr_addr,
    output var  logic                         sram_clear_busy
);
    // ****************************************************************
    // state: synchronisers for asynchronous event inputs, register fields and registered outputs
    // ****************************************************************
    typedef struct packed {
        logic [3:0] sync1;       // first stage, read only by second
        logic [3:0] sync2;       // second stage
        logic [3:0] prev;        // edge detect history
        logic [7:0] current;     // current code
        logic [1:0] osc;         // oscillator range
        logic       skip;        // sram init skip
        logic       reboot;      // repeated boot flag
        logic       booted;      // boot seen once
        logic       start;       // clear start pulse
        logic       keep;        // keep range on this clear
        logic [7:0] cur_out;     // registered output copies
        logic [7:0] prox_out;
        logic [1:0] osc_out;
        logic       osc_ok;
        logic       wr_en;
        logic [7:0] wr_addr;
        logic       busy;
    } bank_state_t;

    bank_state_t st;      // registered state
    bank_state_t next_st; // next state

    // ****************************************************************
    // bus front end
    // ****************************************************************
    logic                 wr_stb;  // register write strobe
    logic [ADDR_W-1:0]    wr_addr; // write address
    logic [7:0]           wr_data; // write data low byte
    logic                 rd_stb;  // read strobe
    logic [ADDR_W-1:0]    rd_addr; // read address
    logic [7:0]           rd_data; // read data
    logic                 rd_hit;  // mapped read
    logic                 wr_hit;  // mapped write

    // mapped address decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_CURRENT) || (a == ADDR_SYSCTL);
    endfunction : is_mapped

    axil_reg_port u_port (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .awaddr  (s_awaddr),
        .awvalid (s_awvalid),
        .awready (s_awready),
        .wdata   (s_wdata),
        .wstrb   (s_wstrb),
        .wvalid  (s_wvalid),
        .wready  (s_wready),
        .bresp   (s_bresp),
        .bvalid  (s_bvalid),
        .bready  (s_bready),
        .araddr  (s_araddr),
        .arvalid (s_arvalid),
        .arready (s_arready),
        .rdata   (s_rdata),
        .rresp   (s_rresp),
        .rvalid  (s_rvalid),
        .rready  (s_rready),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit),
        .wr_hit  (wr_hit)
    );

    // ****************************************************************
    // sram clear sequencer
    // ****************************************************************
    sram_clear_if clr_if ();

    sram_clear_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .clr     (clr_if.seq)
    );

    assign clr_if.start      = st.start;
    assign clr_if.keep_range = st.keep;

    // ****************************************************************
    // read mux and decode
    // ****************************************************************
    always_comb begin
        rd_hit  = is_mapped(rd_addr);
        wr_hit  = is_mapped(wr_addr);
        rd_data = 8'h00;
        if (rd_addr == ADDR_CURRENT) begin
            rd_data = st.current;                       // [RULE_01]
        end else if (rd_addr == ADDR_SYSCTL) begin
            // reserved bits read zero
            rd_data[BIT_REBOOT]            = st.reboot;  // [RULE_05] [RULE_06]
            rd_data[BIT_OSC_HI:BIT_OSC_LO] = st.osc;
            rd_data[BIT_SKIP]              = st.skip;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    logic [3:0] rise; // rising edges of synchronised events

    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        next_st.sync1 = {watchdog_reset_event, external_reset_input, por_event, boot_done};
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        rise          = st.sync2 & ~st.prev;
        // boot completion: second boot marks repeat [RULE_05] [RULE_06]
        if (rise[0]) begin
            next_st.booted = 1'b1;
            if (st.booted) begin
                next_st.reboot = 1'b1;
            end
        end
        // power-on clears boot history
        if (rise[1]) begin
            next_st.booted = 1'b0;
            next_st.reboot = 1'b0;
        end
        // reset events trigger sram clear [RULE_09]
        if (rise[1] || rise[2] || rise[3]) begin
            next_st.start = 1'b1;
            // keep range only for watchdog with skip set [RULE_10]
            next_st.keep  = rise[3] && !rise[1] && !rise[2] && st.skip;
        end
        // register writes; flag bit not writable [RULE_04]
        if (wr_stb && wr_addr == ADDR_CURRENT) begin
            next_st.current = wr_data;                  // [RULE_01]
        end
        if (wr_stb && wr_addr == ADDR_SYSCTL) begin
            next_st.osc  = wr_data[BIT_OSC_HI:BIT_OSC_LO]; // [RULE_07]
            next_st.skip = wr_data[BIT_SKIP];
        end
        // outputs registered
        next_st.cur_out  = next_st.current;             // [RULE_02]
        next_st.prox_out = next_st.current;             // [RULE_03]
        next_st.osc_out  = next_st.osc;                 // [RULE_07]
        next_st.osc_ok   = (next_st.osc != OSC_RSVD);
        next_st.wr_en    = clr_if.wr_en;
        next_st.wr_addr  = clr_if.wr_addr;
        next_st.busy     = clr_if.busy;
    end

    // ****************************************************************
    // register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.current <= RST_CURRENT;
            st.osc     <= RST_OSC;
            st.skip    <= RST_SKIP;
            st.osc_ok  <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign current_unit_count   = st.cur_out;
    assign proximity_unit_count = st.prox_out;
    assign osc_range_select     = st.osc_out;
    assign osc_range_valid      = st.osc_ok;
    assign sram_wr_en           = st.wr_en;
    assign sram_wr_addr         = st.wr_addr;
    assign sram_clear_busy      = st.busy;

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_current_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && wr_stb && wr_addr == ADDR_CURRENT) ##1 ce |=> current_unit_count == $past(wr_data, 2)) // [RULE_01]
        else $error("current code not applied");
    a_prox_same: assert property (@(posedge aclk) disable iff (!aresetn)
        proximity_unit_count == current_unit_count)  // [RULE_03]
        else $error("proximity current differs");
    a_count_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
        current_unit_count == st.current) // [RULE_02]
        else $error("unit count not from register");
    a_flag_ro: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && wr_stb && !rise[0] && !rise[1]) |=> st.reboot == $past(st.reboot)) // [RULE_04]
        else $error("repeated boot flag changed by write");
    a_flag_once: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st.booted) |-> !st.reboot)  // [RULE_05]
        else $error("flag set after single boot");
    a_flag_twice: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && rise[0] && st.booted && !rise[1]) |=> st.reboot) // [RULE_06]
        else $error("flag not set on repeated boot");
    a_osc_valid: assert property (@(posedge aclk) disable iff (!aresetn)
        osc_range_valid == (osc_range_select != OSC_RSVD)) // [RULE_07]
        else $error("osc range valid wrong");
    a_clear_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && (rise[1] || rise[2])) |=> st.start && !st.keep) // [RULE_09]
        else $error("full sram clear not started");
    a_wdr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && rise[3] && !rise[1] && !rise[2] && st.skip) |=> st.keep) // [RULE_10]
        else $error("watchdog keep range not honoured");

    c_write_current: cover property (@(posedge aclk) wr_stb && wr_addr == ADDR_CURRENT);
    c_repeat_boot: cover property (@(posedge aclk) st.reboot);
    c_keep_clear: cover property (@(posedge aclk) st.start && st.keep);
endmodule : system_control_regs
`default_nettype wire

// *** sim/system_control_regs_tb.sv ***
// testbench: self-checking bench for the current setting and system control bank
`timescale 1ns/1ps
`default_nettype none
module system_control_regs_tb;
    import sysctl_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic              aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0]       s_wdata = '0, s_rdata, d;
    logic [3:0]        s_wstrb = 4'hF, evv = 4'h0; // evv: boot, por, ext, watchdog
    logic              s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic              s_arvalid = 1'b0, s_rready = 1'b0;
    logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic              osc_range_valid, sram_wr_en, sram_clear_busy;
    logic [1:0]        s_bresp, s_rresp, osc_range_select, r;
    logic [7:0]        current_unit_count, proximity_unit_count, sram_wr_addr;
    logic [7:0]        seed = 8'h39, v;
    int                miscompares = 0, checks_done = 0, nw = 0, nk = 0;

    system_control_regs u_system_control_regs (.aclk, .aresetn, .ce,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .boot_done(evv[3]), .por_event(evv[2]), .external_reset_input(evv[1]),
        .watchdog_reset_event(evv[0]), .current_unit_count, .proximity_unit_count,
        .osc_range_select, .osc_range_valid, .sram_wr_en, .sram_wr_addr, .sram_clear_busy);

    // clock, hang guard, sram write tally
    always #2.5 aclk = ~aclk;
    initial begin
        #60000;
        miscompares++;
        results();
    end
    always @(posedge aclk) begin
        if (sram_wr_en === 1'b1) begin
            nw++;
            if (sram_wr_addr >= 8'h03 && sram_wr_addr <= 8'hD7) nk++;
        end
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic results();
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] x, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= {24'h0, x};
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad = ad | s_awready;
            wd = wd | s_wready;
            @(posedge aclk);
            if (ad) s_awvalid <= 1'b0;
            if (wd) s_wvalid <= 1'b0;
        end
        while (s_bvalid !== 1'b1) @(negedge aclk);
        chk(s_bresp, er);
        @(posedge aclk);
        s_bready <= 1'b0;
    endtask : wr

    // read and compare data and response
    task automatic rck(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do @(negedge aclk); while (s_arready !== 1'b1);
        @(posedge aclk);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) @(negedge aclk);
        d = s_rdata;
        r = s_rresp;
        @(posedge aclk);
        s_rready <= 1'b0;
        chk(d, e);
        chk(r, er);
    endtask : rck

    // pulse one event input (reset cause or boot done), then count sram zero writes
    task automatic ev(input int b, input int en, input int ek);
        @(posedge aclk);
        nw = 0;
        nk = 0;
        evv[b] <= 1'b1;
        repeat (4) @(posedge aclk);
        evv[b] <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(sram_clear_busy, en != 0);
        repeat (290) @(posedge aclk);
        chk(sram_clear_busy, 1'b0);
        chk(nw, en);
        chk(nk, ek);
    endtask : ev
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(osc_range_valid, 1'b1);
        rck(ADDR_CURRENT, 32'h0, RESP_OKAY);
        rck(ADDR_SYSCTL, 32'h0, RESP_OKAY);
        wr(ADDR_SYSCTL, 8'h99, RESP_OKAY);
        rck(ADDR_SYSCTL, 32'h19, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYSCTL, {3'h0, i[1:0], 3'h0}, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(osc_range_select, i[1:0]);
            chk(osc_range_valid, i != 3);
            rck(ADDR_SYSCTL, {27'h0, i[1:0], 3'h0}, RESP_OKAY);
        end
        wr(ADDR_SYSCTL, 8'h01, RESP_OKAY);
        ev(0, 43, 0);
        ev(1, 256, 213);
        wr(ADDR_SYSCTL, 8'h00, RESP_OKAY);
        ev(0, 256, 213);
        ev(3, 0, 0);
        rck(ADDR_SYSCTL, 32'h0, RESP_OKAY);
        ev(3, 0, 0);
        rck(ADDR_SYSCTL, 32'h80, RESP_OKAY);
        wr(ADDR_SYSCTL, 8'h00, RESP_OKAY);
        rck(ADDR_SYSCTL, 32'h80, RESP_OKAY);
        ev(2, 256, 213);
        rck(ADDR_SYSCTL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hFF : seed;
            seed = lfsr(seed);
            wr(ADDR_CURRENT, v, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(current_unit_count, v);
            chk(proximity_unit_count, v);
            rck(ADDR_CURRENT, {24'h0, v}, RESP_OKAY);
        end
        wr(12'h000, 8'h55, RESP_SLVERR);
        rck(12'h000, 32'h0, RESP_SLVERR);
        s_wstrb <= 4'hE;
        wr(ADDR_CURRENT, 8'h11, RESP_OKAY);
        s_wstrb <= 4'hF;
        rck(ADDR_CURRENT, {24'h0, v}, RESP_OKAY);
        results();
    end
endmodule : system_control_regs_tb
`default_nettype wire
